// *** hw/csq_pkg.sv ***
package csq_pkg;

   // ************************************************************
   // Widths and depths
   // ************************************************************
   localparam int CSQ_PC_W = 12;
   localparam int CSQ_STACK_DEPTH = 6;
   localparam int CSQ_DS_AW = 8;
   localparam int CSQ_DW = 8;
   localparam int CSQ_WIN_OFS_W = 6;
   localparam int CSQ_WBASE_W = 7;
   localparam int CSQ_WBASE_MSB = 6;
   localparam int CSQ_ROM_AW_MAX = 13;
   localparam int CSQ_CTX_HIST = 2;
   localparam int CSQ_READ_LATENCY = 2;

   // ************************************************************
   // Data-space map
   // ************************************************************
   localparam logic [7:0] CSQ_WIN_LO = 8'h40;
   localparam logic [7:0] CSQ_WIN_HI = 8'h7F;
   localparam logic [7:0] CSQ_PTR_ONE_OFS = 8'h80;
   localparam logic [7:0] CSQ_PTR_TWO_OFS = 8'h81;
   localparam logic [7:0] CSQ_SAVE_ONE_OFS = 8'h82;
   localparam logic [7:0] CSQ_SAVE_TWO_OFS = 8'h83;
   localparam logic [7:0] CSQ_WBASE_OFS = 8'hC9;
   localparam logic [7:0] CSQ_ACC_OFS = 8'hFF;

   // ************************************************************
   // Reset values and PC increment
   // ************************************************************
   localparam logic [7:0] CSQ_REG_RST = 8'h00;
   localparam logic [7:0] CSQ_NO_DATA = 8'h00;
   localparam logic [11:0] CSQ_PC_INC = 12'h001;
   localparam logic [11:0] CSQ_RESET_VEC = 12'hFFE;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      CSQ_CTX_NORMAL,
      CSQ_CTX_IRQ,
      CSQ_CTX_NMI
   } csq_ctx_t;

   typedef enum logic [3:0] {
      CSQ_OP_HOLD,
      CSQ_OP_NEXT,
      CSQ_OP_JUMP,
      CSQ_OP_CALL,
      CSQ_OP_REL,
      CSQ_OP_IRQ,
      CSQ_OP_NMI,
      CSQ_OP_RET,
      CSQ_OP_INTERRUPT_EXIT_OP
   } csq_op_t;

endpackage : csq_pkg

// *** hw/csq_core_seq.sv ***
`timescale 1ns/1ns
`default_nettype none

module csq_core_seq
   import csq_pkg::*;
#(
   parameter int ROM_AW = CSQ_ROM_AW_MAX,
   parameter logic [11:0] RESET_VECTOR = CSQ_RESET_VEC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire csq_op_t seq_op,
   input wire logic [11:0] seq_target,
   input wire logic [7:0] seq_offset,
   input wire logic [11:0] seq_vector,
   input wire logic alu_carry_we,
   input wire logic alu_carry,
   input wire logic alu_zero_we,
   input wire logic alu_zero,
   input wire logic alu_acc_we,
   input wire logic [7:0] alu_acc_wdata,
   input wire logic [7:0] ds_addr,
   input wire logic ds_rd,
   input wire logic ds_wr,
   input wire logic ds_bitop,
   input wire logic [7:0] ds_wdata,
   input wire logic [7:0] rom_rdata,
   output logic [11:0] program_counter_r,
   output csq_ctx_t context_r,
   output logic carry_flag_r,
   output logic zero_flag_r,
   output logic [2:0] stack_depth_r,
   output logic [7:0] accumulator_r,
   output logic [7:0] indirect_pointer_one_r,
   output logic [7:0] indirect_pointer_two_r,
   output logic [7:0] short_direct_save_one_r,
   output logic [7:0] short_direct_save_two_r,
   output logic [ROM_AW-1:0] rom_addr_r,
   output logic rom_rd_r,
   output logic ds_rvalid_r,
   output logic [7:0] ds_rdata_r
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   if (ROM_AW < CSQ_WBASE_W || ROM_AW > CSQ_ROM_AW_MAX) begin : g_bad_aw
      $error("ROM_AW out of range");
   end

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [11:0] stk_r [CSQ_STACK_DEPTH];
   logic [11:0] stk_nxt [CSQ_STACK_DEPTH];
   logic [11:0] pc_nxt;
   logic [11:0] rel_sum;
   logic [2:0] depth_nxt;
   logic push;
   logic pop;
   csq_ctx_t ctx_nxt;
   csq_ctx_t hist_r [CSQ_CTX_HIST];
   logic [1:0] hdepth_r;
   logic c_bank_r [3];
   logic z_bank_r [3];
   logic c_bank_nxt [3];
   logic z_bank_nxt [3];
   logic [CSQ_WBASE_W-1:0] wbase_r;
   logic [CSQ_ROM_AW_MAX-1:0] win_addr;
   logic win_hit;
   logic wbase_wr;
   logic [7:0] reg_rdata;
   logic rd_pend_r;
   logic rd_win_r;
   logic [7:0] rd_data_r;

   // ************************************************************
   // Program counter
   // ************************************************************
   // Relative branches pass through the adder with a sign-extended offset
   assign rel_sum = program_counter_r + {{4{seq_offset[7]}}, seq_offset};
   assign push = (seq_op == CSQ_OP_CALL) || (seq_op == CSQ_OP_IRQ) || (seq_op == CSQ_OP_NMI);
   assign pop = (seq_op == CSQ_OP_RET) || (seq_op == CSQ_OP_INTERRUPT_EXIT_OP);

   always_comb begin
      case (seq_op)
         CSQ_OP_HOLD: pc_nxt = program_counter_r;
         CSQ_OP_NEXT: pc_nxt = program_counter_r + CSQ_PC_INC;
         CSQ_OP_JUMP: pc_nxt = seq_target;
         CSQ_OP_CALL: pc_nxt = seq_target;
         CSQ_OP_REL: pc_nxt = rel_sum;
         CSQ_OP_IRQ: pc_nxt = seq_vector;
         CSQ_OP_NMI: pc_nxt = seq_vector;
         CSQ_OP_RET, CSQ_OP_INTERRUPT_EXIT_OP: begin
            // Empty stack: continue with the next byte
            if (stack_depth_r == 3'h0) begin
               pc_nxt = program_counter_r + CSQ_PC_INC;
            end else begin
               pc_nxt = stk_r[0];
            end
         end
         default: pc_nxt = program_counter_r;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         program_counter_r <= RESET_VECTOR;
      end else begin
         program_counter_r <= pc_nxt;
      end
   end

   // ************************************************************
   // Return stack
   // ************************************************************
   for (genvar i = 0; i < CSQ_STACK_DEPTH; i++) begin : g_stk
      always_comb begin
         if (push) begin
            stk_nxt[i] = (i == 0) ? program_counter_r : stk_r[(i == 0) ? 0 : i - 1];
         end else if (pop && stack_depth_r != 3'h0) begin
            stk_nxt[i] = stk_r[(i == CSQ_STACK_DEPTH - 1) ? i : i + 1];
         end else begin
            stk_nxt[i] = stk_r[i];
         end
      end
      always_ff @(posedge clk) begin
         if (!reset_n) begin
            stk_r[i] <= 12'h000;
         end else begin
            stk_r[i] <= stk_nxt[i];
         end
      end
   end

   always_comb begin
      depth_nxt = stack_depth_r;
      if (push && stack_depth_r != 3'(CSQ_STACK_DEPTH)) begin
         depth_nxt = stack_depth_r + 3'h1;
      end else if (pop && stack_depth_r != 3'h0) begin
         depth_nxt = stack_depth_r - 3'h1;
      end
   end

   // Depth saturates at six and never underflows
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stack_depth_r <= 3'h0;
      end else begin
         stack_depth_r <= depth_nxt;
      end
   end

   // ************************************************************
   // Context and flag banks
   // ************************************************************
   always_comb begin
      case (seq_op)
         CSQ_OP_IRQ: ctx_nxt = CSQ_CTX_IRQ;
         CSQ_OP_NMI: ctx_nxt = CSQ_CTX_NMI;
         CSQ_OP_INTERRUPT_EXIT_OP: ctx_nxt = (hdepth_r != 2'h0) ? hist_r[0] : CSQ_CTX_NORMAL;
         default: ctx_nxt = context_r;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         context_r <= CSQ_CTX_NMI;
         hist_r[0] <= CSQ_CTX_NORMAL;
         hist_r[1] <= CSQ_CTX_NORMAL;
         hdepth_r <= 2'h0;
      end else begin
         context_r <= ctx_nxt;
         if (seq_op == CSQ_OP_IRQ || seq_op == CSQ_OP_NMI) begin
            hist_r[0] <= context_r;
            hist_r[1] <= hist_r[0];
            if (hdepth_r != 2'(CSQ_CTX_HIST)) begin
               hdepth_r <= hdepth_r + 2'h1;
            end
         end else if (seq_op == CSQ_OP_INTERRUPT_EXIT_OP && hdepth_r != 2'h0) begin
            hist_r[0] <= hist_r[1];
            hdepth_r <= hdepth_r - 2'h1;
         end
      end
   end

   // Only the bank of the running context is written; others keep their state
   for (genvar g = 0; g < 3; g++) begin : g_bank
      assign c_bank_nxt[g] = (context_r == csq_ctx_t'(g) && alu_carry_we) ? alu_carry
                                                                         : c_bank_r[g];
      assign z_bank_nxt[g] = (context_r == csq_ctx_t'(g) && alu_zero_we) ? alu_zero
                                                                        : z_bank_r[g];
      always_ff @(posedge clk) begin
         if (!reset_n) begin
            c_bank_r[g] <= 1'b0;
            z_bank_r[g] <= 1'b0;
         end else begin
            c_bank_r[g] <= c_bank_nxt[g];
            z_bank_r[g] <= z_bank_nxt[g];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         carry_flag_r <= 1'b0;
         zero_flag_r <= 1'b0;
      end else begin
         carry_flag_r <= c_bank_nxt[ctx_nxt];
         zero_flag_r <= z_bank_nxt[ctx_nxt];
      end
   end

   // ************************************************************
   // Data-space registers
   // ************************************************************
   assign wbase_wr = ds_wr && !ds_bitop && ds_addr == CSQ_WBASE_OFS;

   // Window base deliberately has no reset
   always_ff @(posedge clk) begin
      if (wbase_wr) begin
         wbase_r <= ds_wdata[CSQ_WBASE_MSB:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         accumulator_r <= CSQ_REG_RST;
      end else if (alu_acc_we) begin
         accumulator_r <= alu_acc_wdata;
      end else if (ds_wr && ds_addr == CSQ_ACC_OFS) begin
         accumulator_r <= ds_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         indirect_pointer_one_r <= CSQ_REG_RST;
         indirect_pointer_two_r <= CSQ_REG_RST;
         short_direct_save_one_r <= CSQ_REG_RST;
         short_direct_save_two_r <= CSQ_REG_RST;
      end else if (ds_wr) begin
         case (ds_addr)
            CSQ_PTR_ONE_OFS: indirect_pointer_one_r <= ds_wdata;
            CSQ_PTR_TWO_OFS: indirect_pointer_two_r <= ds_wdata;
            CSQ_SAVE_ONE_OFS: short_direct_save_one_r <= ds_wdata;
            CSQ_SAVE_TWO_OFS: short_direct_save_two_r <= ds_wdata;
            default: ;
         endcase
      end
   end

   // ************************************************************
   // Data-space reads and ROM window
   // ************************************************************
   assign win_hit = ds_addr >= CSQ_WIN_LO && ds_addr <= CSQ_WIN_HI;
   assign win_addr = {wbase_r, ds_addr[CSQ_WIN_OFS_W-1:0]};

   always_comb begin
      case (ds_addr)
         CSQ_PTR_ONE_OFS: reg_rdata = indirect_pointer_one_r;
         CSQ_PTR_TWO_OFS: reg_rdata = indirect_pointer_two_r;
         CSQ_SAVE_ONE_OFS: reg_rdata = short_direct_save_one_r;
         CSQ_SAVE_TWO_OFS: reg_rdata = short_direct_save_two_r;
         CSQ_ACC_OFS: reg_rdata = accumulator_r;
         default: reg_rdata = CSQ_NO_DATA;
      endcase
   end

   // Stage one: issue ROM fetch or latch register data
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rd_pend_r <= 1'b0;
         rd_win_r <= 1'b0;
         rd_data_r <= CSQ_NO_DATA;
         rom_rd_r <= 1'b0;
         rom_addr_r <= '0;
      end else begin
         rd_pend_r <= ds_rd;
         rd_win_r <= ds_rd && win_hit;
         rd_data_r <= reg_rdata;
         rom_rd_r <= ds_rd && win_hit;
         if (ds_rd && win_hit) begin
            rom_addr_r <= win_addr[ROM_AW-1:0];
         end
      end
   end

   // Stage two: answer
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ds_rvalid_r <= 1'b0;
         ds_rdata_r <= CSQ_NO_DATA;
      end else begin
         ds_rvalid_r <= rd_pend_r;
         ds_rdata_r <= rd_win_r ? rom_rdata : rd_data_r;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_irq_from_normal;
      context_r == CSQ_CTX_NORMAL && seq_op == CSQ_OP_IRQ;
   endsequence

   sequence s_interrupt_exit_op_now;
      seq_op == CSQ_OP_INTERRUPT_EXIT_OP;
   endsequence

   a_win_rom_addr: assert property (ds_rd && win_hit |=> rom_rd_r &&
      rom_addr_r == $past(win_addr[ROM_AW-1:0])) else $error("window address wrong");
   a_win_answer: assert property (ds_rd && win_hit |-> ##2 ds_rvalid_r &&
      ds_rdata_r == $past(rom_rdata)) else $error("window data wrong");
   a_wbase_write: assert property (wbase_wr |=> wbase_r == $past(ds_wdata[6:0]))
      else $error("window base not written");
   a_wbase_bitop: assert property (ds_wr && ds_bitop && ds_addr == CSQ_WBASE_OFS
      |=> wbase_r == $past(wbase_r)) else $error("bit op changed window base");
   a_wbase_read: assert property (ds_rd && !ds_wr && ds_addr == CSQ_WBASE_OFS |-> ##2
      ds_rvalid_r && ds_rdata_r == CSQ_NO_DATA) else $error("window base read data");
   a_acc_map: assert property (ds_wr && !alu_acc_we && ds_addr == CSQ_ACC_OFS
      |=> accumulator_r == $past(ds_wdata)) else $error("accumulator map");
   a_ptr_read: assert property (ds_rd && ds_addr == CSQ_PTR_TWO_OFS |-> ##2
      ds_rdata_r == $past(indirect_pointer_two_r, 2)) else $error("pointer read");
   a_save_map: assert property (ds_wr && ds_addr == CSQ_SAVE_TWO_OFS
      |=> short_direct_save_two_r == $past(ds_wdata)) else $error("save register map");
   a_pc_incr: assert property (seq_op == CSQ_OP_NEXT |=>
      program_counter_r == $past(program_counter_r) + CSQ_PC_INC) else $error("pc incr");
   a_pc_rel: assert property (seq_op == CSQ_OP_REL |=> program_counter_r ==
      $past(program_counter_r) + {{4{$past(seq_offset[7])}}, $past(seq_offset)})
      else $error("relative branch");
   a_call_push: assert property (seq_op == CSQ_OP_CALL |=> stk_r[0] ==
      $past(program_counter_r) && program_counter_r == $past(seq_target) &&
      stk_r[1] == $past(stk_r[0])) else $error("call push");
   a_ret_pop: assert property (seq_op == CSQ_OP_RET && stack_depth_r != 3'h0 |=>
      program_counter_r == $past(stk_r[0]) && stk_r[0] == $past(stk_r[1]))
      else $error("return pop");
   a_ret_empty: assert property (pop && stack_depth_r == 3'h0 |=> stack_depth_r == 3'h0
      && program_counter_r == $past(program_counter_r) + CSQ_PC_INC)
      else $error("empty return");
   a_depth_sat: assert property (push && stack_depth_r == 3'(CSQ_STACK_DEPTH)
      |=> stack_depth_r == 3'(CSQ_STACK_DEPTH)) else $error("depth overflow");
   a_ctx_round: assert property (s_irq_from_normal ##1 s_interrupt_exit_op_now
      |=> context_r == CSQ_CTX_NORMAL) else $error("context not restored");
   a_ctx_entry: assert property (seq_op == CSQ_OP_NMI |=> context_r == CSQ_CTX_NMI)
      else $error("nmi entry");
   a_flag_keep: assert property (s_irq_from_normal ##1 s_interrupt_exit_op_now ##1
      (!alu_carry_we && !alu_zero_we) |=> carry_flag_r == $past(c_bank_r[0], 3))
      else $error("normal flags lost");
   a_carry_set: assert property (alu_carry_we && seq_op != CSQ_OP_IRQ &&
      seq_op != CSQ_OP_NMI && seq_op != CSQ_OP_INTERRUPT_EXIT_OP |=> carry_flag_r == $past(alu_carry))
      else $error("carry update");
   a_zero_set: assert property (alu_zero_we && seq_op != CSQ_OP_IRQ &&
      seq_op != CSQ_OP_NMI && seq_op != CSQ_OP_INTERRUPT_EXIT_OP |=> zero_flag_r == $past(alu_zero))
      else $error("zero update");
   a_reset_nmi: assert property ($rose(reset_n) |-> context_r == CSQ_CTX_NMI)
      else $error("reset context");

endmodule : csq_core_seq

`default_nettype wire

// *** dv/csq_rom_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Combinational program ROM seen through the window port
// ************************************************************
module csq_rom_model (
   input wire logic clk,
   input wire logic [12:0] rom_addr,
   input wire logic rom_rd,
   output logic [7:0] rom_rdata
);
   logic [7:0] last_r;

   // Content pattern mixes high and low address bits so a wrong base shows
   function automatic logic [7:0] rom_byte(input logic [12:0] a);
      return a[7:0] ^ {a[12:8], 3'h5};
   endfunction : rom_byte

   // Outside a read the bus shows the inverse of its previous-cycle value, so it toggles every idle cycle
   always_ff @(posedge clk) begin
      last_r <= rom_rdata;
   end

   always_comb begin
      rom_rdata = rom_rd ? rom_byte(rom_addr) : ~last_r;
   end
endmodule : csq_rom_model

`default_nettype wire

// *** dv/core_sequencer_rom_window_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module core_sequencer_rom_window_tb_top import csq_pkg::*;;
   logic clk, reset_n, alu_carry_we, alu_carry, alu_zero_we, alu_zero, alu_acc_we;
   logic ds_rd, ds_wr, ds_bitop, rom_rd_r, ds_rvalid_r, carry_flag_r, zero_flag_r;
   csq_op_t seq_op;
   csq_ctx_t context_r;
   logic [11:0] seq_target, seq_vector, program_counter_r;
   logic [7:0] seq_offset, alu_acc_wdata, ds_addr, ds_wdata, rom_rdata, ds_rdata_r;
   logic [7:0] accumulator_r, ptr_one, ptr_two, save_one, save_two;
   logic [2:0] stack_depth_r;
   logic [12:0] rom_addr_r;
   int num_errors = 0;
   int check_count = 0;

   csq_core_seq DUT (.clk(clk), .reset_n(reset_n), .seq_op(seq_op), .seq_target(seq_target),
      .seq_offset(seq_offset), .seq_vector(seq_vector), .alu_carry_we(alu_carry_we),
      .alu_carry(alu_carry), .alu_zero_we(alu_zero_we), .alu_zero(alu_zero),
      .alu_acc_we(alu_acc_we), .alu_acc_wdata(alu_acc_wdata), .ds_addr(ds_addr),
      .ds_rd(ds_rd), .ds_wr(ds_wr), .ds_bitop(ds_bitop), .ds_wdata(ds_wdata),
      .rom_rdata(rom_rdata), .program_counter_r(program_counter_r), .context_r(context_r),
      .carry_flag_r(carry_flag_r), .zero_flag_r(zero_flag_r), .stack_depth_r(stack_depth_r),
      .accumulator_r(accumulator_r), .indirect_pointer_one_r(ptr_one),
      .indirect_pointer_two_r(ptr_two), .short_direct_save_one_r(save_one),
      .short_direct_save_two_r(save_two), .rom_addr_r(rom_addr_r), .rom_rd_r(rom_rd_r),
      .ds_rvalid_r(ds_rvalid_r), .ds_rdata_r(ds_rdata_r));

   csq_rom_model rom (.clk(clk), .rom_addr(rom_addr_r), .rom_rd(rom_rd_r),
      .rom_rdata(rom_rdata));

   always #2 clk = ~clk;

   // ************************************************************
   // Shared helpers
   // ************************************************************
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   function automatic logic [7:0] exp_rom(input logic [12:0] a);
      return a[7:0] ^ {a[12:8], 3'h5};
   endfunction : exp_rom

   task automatic ds_write(input logic [7:0] a, input logic [7:0] d, input logic bit_op);
      @(posedge clk);
      ds_wr <= 1'b1;
      ds_addr <= a;
      ds_wdata <= d;
      ds_bitop <= bit_op;
      @(posedge clk);
      ds_wr <= 1'b0;
      ds_bitop <= 1'b0;
   endtask : ds_write

   task automatic ds_read(input logic [7:0] a, output logic [7:0] d, output logic [12:0] ra,
                          output logic rr);
      @(posedge clk);
      ds_rd <= 1'b1;
      ds_addr <= a;
      @(posedge clk);
      ds_rd <= 1'b0;
      #1;
      ra = rom_addr_r;
      rr = rom_rd_r;
      chk("early_valid", 16'h0000, {15'h0000, ds_rvalid_r});
      @(posedge clk);
      #1;
      chk("read_valid", 16'h0001, {15'h0000, ds_rvalid_r});
      d = ds_rdata_r;
   endtask : ds_read

   task automatic seq(input csq_op_t op, input logic [11:0] val, input logic [7:0] ofs);
      @(posedge clk);
      seq_op <= op;
      seq_target <= val;
      seq_vector <= val;
      seq_offset <= ofs;
      @(posedge clk);
      seq_op <= CSQ_OP_HOLD;
      #1;
   endtask : seq

   task automatic set_flags(input logic c, input logic z);
      @(posedge clk);
      alu_carry_we <= 1'b1;
      alu_carry <= c;
      alu_zero_we <= 1'b1;
      alu_zero <= z;
      @(posedge clk);
      alu_carry_we <= 1'b0;
      alu_zero_we <= 1'b0;
      #1;
   endtask : set_flags

   task automatic chk_ctx(input csq_ctx_t ctx, input logic c, input logic z);
      chk("context", {14'h0000, ctx}, {14'h0000, context_r});
      chk("flags", {14'h0000, c, z}, {14'h0000, carry_flag_r, zero_flag_r});
   endtask : chk_ctx

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      chk("pc_reset", {4'h0, CSQ_RESET_VEC}, {4'h0, program_counter_r});
      chk_ctx(CSQ_CTX_NMI, 1'b0, 1'b0);
      chk("depth_reset", 16'h0000, {13'h0000, stack_depth_r});
   endtask : t_reset

   task automatic t_regs();
      logic [7:0] a[5] = '{CSQ_PTR_ONE_OFS, CSQ_PTR_TWO_OFS, CSQ_SAVE_ONE_OFS,
                           CSQ_SAVE_TWO_OFS, CSQ_ACC_OFS};
      logic [7:0] d;
      logic [12:0] ra;
      logic rr;
      for (int i = 0; i < 5; i++) begin
         ds_write(a[i], 8'h11 * 8'(i + 1), 1'b0);
      end
      #1;
      chk("ptr_one", 16'h0011, {8'h00, ptr_one});
      chk("ptr_two", 16'h0022, {8'h00, ptr_two});
      chk("save_one", 16'h0033, {8'h00, save_one});
      chk("save_two", 16'h0044, {8'h00, save_two});
      chk("acc", 16'h0055, {8'h00, accumulator_r});
      for (int i = 0; i < 5; i++) begin
         ds_read(a[i], d, ra, rr);
         chk("reg_read", {8'h00, 8'h11 * 8'(i + 1)}, {8'h00, d});
      end
      @(posedge clk);
      alu_acc_we <= 1'b1;
      alu_acc_wdata <= 8'hA5;
      ds_wr <= 1'b1;
      ds_addr <= CSQ_ACC_OFS;
      ds_wdata <= 8'h3C;
      @(posedge clk);
      alu_acc_we <= 1'b0;
      ds_wr <= 1'b0;
      #1;
      chk("acc_alu_wins", 16'h00A5, {8'h00, accumulator_r});
   endtask : t_regs

   task automatic t_window();
      logic [7:0] d;
      logic [12:0] ra;
      logic rr;
      ds_write(CSQ_WBASE_OFS, 8'hA8, 1'b0);
      ds_read(8'h59, d, ra, rr);
      chk("win_addr", 16'h0A19, {3'h0, ra});
      chk("win_rd", 16'h0001, {15'h0000, rr});
      chk("win_data", {8'h00, exp_rom(13'h0A19)}, {8'h00, d});
      ds_write(CSQ_WBASE_OFS, 8'h10, 1'b1);
      ds_read(CSQ_WBASE_OFS, d, ra, rr);
      chk("base_read", {8'h00, CSQ_NO_DATA}, {8'h00, d});
      ds_read(8'h59, d, ra, rr);
      chk("bitop_ignored", 16'h0A19, {3'h0, ra});
      ds_write(CSQ_WBASE_OFS, 8'h7F, 1'b0);
      ds_read(8'h7F, d, ra, rr);
      chk("win_top", 16'h1FFF, {3'h0, ra});
      chk("win_top_data", {8'h00, exp_rom(13'h1FFF)}, {8'h00, d});
      ds_read(8'h40, d, ra, rr);
      chk("win_bottom", 16'h1FC0, {3'h0, ra});
      ds_read(8'h3F, d, ra, rr);
      chk("below_window", 16'h0000, {15'h0000, rr});
   endtask : t_window

   task automatic t_pc();
      seq(CSQ_OP_JUMP, 12'hFFF, 8'h00);
      seq(CSQ_OP_NEXT, 12'h000, 8'h00);
      chk("pc_wrap", 16'h0000, {4'h0, program_counter_r});
      seq(CSQ_OP_JUMP, 12'h100, 8'h00);
      seq(CSQ_OP_REL, 12'h000, 8'hFE);
      chk("rel_back", 16'h00FE, {4'h0, program_counter_r});
      seq(CSQ_OP_REL, 12'h000, 8'h05);
      chk("rel_fwd", 16'h0103, {4'h0, program_counter_r});
      seq(CSQ_OP_HOLD, 12'h000, 8'h00);
      chk("pc_hold", 16'h0103, {4'h0, program_counter_r});
   endtask : t_pc

   task automatic t_stack();
      seq(CSQ_OP_JUMP, 12'h100, 8'h00);
      for (int i = 0; i < 7; i++) begin
         seq(CSQ_OP_CALL, 12'h200 + 12'(i), 8'h00);
         chk("call_pc", 16'h0200 + 16'(i), {4'h0, program_counter_r});
         chk("call_depth", (i < 6) ? 16'(i + 1) : 16'h0006, {13'h0, stack_depth_r});
      end
      for (int i = 5; i >= 0; i--) begin
         seq(CSQ_OP_RET, 12'h000, 8'h00);
         chk("ret_pc", 16'h0200 + 16'(i), {4'h0, program_counter_r});
         chk("ret_depth", 16'(i), {13'h0, stack_depth_r});
      end
      seq(CSQ_OP_RET, 12'h000, 8'h00);
      chk("empty_ret", 16'h0201, {4'h0, program_counter_r});
      chk("empty_depth", 16'h0000, {13'h0, stack_depth_r});
   endtask : t_stack

   task automatic t_context();
      set_flags(1'b1, 1'b0);
      chk_ctx(CSQ_CTX_NMI, 1'b1, 1'b0);
      seq(CSQ_OP_INTERRUPT_EXIT_OP, 12'h000, 8'h00);
      chk_ctx(CSQ_CTX_NORMAL, 1'b0, 1'b0);
      set_flags(1'b0, 1'b1);
      seq(CSQ_OP_IRQ, 12'h010, 8'h00);
      chk("irq_pc", 16'h0010, {4'h0, program_counter_r});
      chk_ctx(CSQ_CTX_IRQ, 1'b0, 1'b0);
      set_flags(1'b1, 1'b1);
      seq(CSQ_OP_INTERRUPT_EXIT_OP, 12'h000, 8'h00);
      chk_ctx(CSQ_CTX_NORMAL, 1'b0, 1'b1);
      seq(CSQ_OP_NMI, 12'h020, 8'h00);
      chk_ctx(CSQ_CTX_NMI, 1'b1, 1'b0);
      seq(CSQ_OP_INTERRUPT_EXIT_OP, 12'h000, 8'h00);
      chk_ctx(CSQ_CTX_NORMAL, 1'b0, 1'b1);
      // Interrupt entry followed at once by its return, no flag writes
      @(posedge clk);
      seq_op <= CSQ_OP_IRQ;
      seq_vector <= 12'h030;
      @(posedge clk);
      seq_op <= CSQ_OP_INTERRUPT_EXIT_OP;
      @(posedge clk);
      seq_op <= CSQ_OP_HOLD;
      repeat (2) @(posedge clk);
      #1;
      chk_ctx(CSQ_CTX_NORMAL, 1'b0, 1'b1);
      chk("irq_interrupt_exit_op_depth", 16'h0000, {13'h0, stack_depth_r});
   endtask : t_context

   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      complete_run();
   end

   initial begin
      {clk, reset_n, alu_carry_we, alu_carry, alu_zero_we, alu_zero} = '0;
      {alu_acc_we, ds_rd, ds_wr, ds_bitop} = '0;
      {seq_target, seq_vector, seq_offset, alu_acc_wdata, ds_addr, ds_wdata} = '0;
      seq_op = CSQ_OP_HOLD;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      t_reset();
      t_context();
      t_regs();
      t_window();
      t_pc();
      t_stack();
      complete_run();
   end
endmodule : core_sequencer_rom_window_tb_top

`default_nettype wire
